// >>> verilog/pdc_map.vh
`ifndef PDC_MAP_VH
`define PDC_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PDC_A_FB_HI 8'h00
`define PDC_A_FB_LO 8'h01
`define PDC_A_SEC_LO 8'h02
`define PDC_A_CHAIN 8'h03
`define PDC_A_REF_HI 8'h04
`define PDC_A_REF_LO 8'h05
`define PDC_A_SYN_HI 8'h08
`define PDC_A_SYN_LO 8'h09
`define PDC_A_SIN 8'h0c
`define PDC_A_OSC 8'h1f
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PDC_RST_FB_DIV 12'hc00
`define PDC_RST_REF_DIV 12'hc00
`define PDC_RST_SEC_DIV 9'h060
`define PDC_RST_SYN_DIV 9'h018
`define PDC_RST_SIN_DIV 6'h00
`define PDC_RST_PHASE 3'h0
`define PDC_RST_BIT 1'b0
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PDC_F_PHASE 7:5
`define PDC_F_PD 4
`define PDC_F_HI 3:0
`define PDC_F_SEC8 7
`define PDC_F_CHAIN 0
`define PDC_F_SYN8 0
`define PDC_F_DBL 7
`define PDC_F_SIN 5:0
`define PDC_F_OSC 0
`define PDC_DIV_HI 11:8
`define PDC_DIV_LO 7:0
`define PDC_BIT8 8
`endif

// >>> verilog/pdc_top.v
// Operation
// - Feedback phase field with reference phase field sets lock window; resets zero.
// - Lock sampling phase is placed relative to first-stage detector clock edge.
// - First feedback divider divides by 12-bit value; resets to 3072.
// - Second feedback divider is 9 bits, split low byte and high bit; resets 96.
// - Second divider powers down when its power-down bit is one.
// - Reference pre-divider divides first-stage input by 12-bit value; resets 3072.
// - Synthesizer loop divider divides by 9-bit value; resets to 24.
// - Synthesizer input divider divides by 6-bit value; zero bypasses it.
// - Doubler select feeds doubled first-stage output and ignores input divider.
// - Chain select zero uses first divider only; one uses both in series.
`timescale 1ns/1ns
`include "pdc_map.vh"
module pdc_top #(
  parameter PH_W = 3
) (
  input wire ref_clk,
  input wire srst,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire ref_in,
  input wire osc_in,
  input wire synth_in,
  output reg ref_div_out,
  output reg fb_div_out,
  output reg sec_div_out,
  output reg lock_sample,
  output reg synth_loop_out,
  output reg synth_in_out
);
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  reg [PH_W-1:0] feedback_phase_sel;
  reg [PH_W-1:0] ref_phase_sel;
  reg [11:0] first_feedback_div;
  reg [8:0] second_feedback_div;
  reg second_div_powerdown;
  reg [11:0] ref_pre_div;
  reg [8:0] synth_loop_div;
  reg [5:0] synth_input_div;
  reg freq_doubler_sel;
  reg feedback_chain_sel;
  reg oscillator_choice;
  reg [7:0] next_rdata;

  always @(posedge ref_clk) begin
    if (srst) begin
      feedback_phase_sel <= `PDC_RST_PHASE;
      ref_phase_sel <= `PDC_RST_PHASE;
      first_feedback_div <= `PDC_RST_FB_DIV;
      second_feedback_div <= `PDC_RST_SEC_DIV;
      second_div_powerdown <= `PDC_RST_BIT;
      ref_pre_div <= `PDC_RST_REF_DIV;
      synth_loop_div <= `PDC_RST_SYN_DIV;
      synth_input_div <= `PDC_RST_SIN_DIV;
      freq_doubler_sel <= `PDC_RST_BIT;
      feedback_chain_sel <= `PDC_RST_BIT;
      oscillator_choice <= `PDC_RST_BIT;
    end else if (reg_wr) begin
      // Reserved bits are simply not stored, so neighbours are untouched.
      case (reg_addr)
        `PDC_A_FB_HI: begin
          feedback_phase_sel <= reg_wdata[`PDC_F_PHASE];
          second_div_powerdown <= reg_wdata[`PDC_F_PD];
          first_feedback_div[`PDC_DIV_HI] <= reg_wdata[`PDC_F_HI];
        end
        `PDC_A_FB_LO: first_feedback_div[`PDC_DIV_LO] <= reg_wdata;
        `PDC_A_SEC_LO: second_feedback_div[`PDC_DIV_LO] <= reg_wdata;
        `PDC_A_CHAIN: begin
          second_feedback_div[`PDC_BIT8] <= reg_wdata[`PDC_F_SEC8];
          feedback_chain_sel <= reg_wdata[`PDC_F_CHAIN];
        end
        `PDC_A_REF_HI: begin
          ref_phase_sel <= reg_wdata[`PDC_F_PHASE];
          ref_pre_div[`PDC_DIV_HI] <= reg_wdata[`PDC_F_HI];
        end
        `PDC_A_REF_LO: ref_pre_div[`PDC_DIV_LO] <= reg_wdata;
        `PDC_A_SYN_HI: synth_loop_div[`PDC_BIT8] <= reg_wdata[`PDC_F_SYN8];
        `PDC_A_SYN_LO: synth_loop_div[`PDC_DIV_LO] <= reg_wdata;
        `PDC_A_SIN: begin
          freq_doubler_sel <= reg_wdata[`PDC_F_DBL];
          synth_input_div <= reg_wdata[`PDC_F_SIN];
        end
        `PDC_A_OSC: oscillator_choice <= reg_wdata[`PDC_F_OSC];
        default: begin
        end
      endcase
    end
  end

  // Bits that no field claims keep the zero given here, so reserved bits read as zero.
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `PDC_A_FB_HI: begin
        next_rdata[`PDC_F_PHASE] = feedback_phase_sel;
        next_rdata[`PDC_F_PD] = second_div_powerdown;
        next_rdata[`PDC_F_HI] = first_feedback_div[`PDC_DIV_HI];
      end
      `PDC_A_FB_LO: next_rdata = first_feedback_div[`PDC_DIV_LO];
      `PDC_A_SEC_LO: next_rdata = second_feedback_div[`PDC_DIV_LO];
      `PDC_A_CHAIN: begin
        next_rdata[`PDC_F_SEC8] = second_feedback_div[`PDC_BIT8];
        next_rdata[`PDC_F_CHAIN] = feedback_chain_sel;
      end
      `PDC_A_REF_HI: begin
        next_rdata[`PDC_F_PHASE] = ref_phase_sel;
        next_rdata[`PDC_F_HI] = ref_pre_div[`PDC_DIV_HI];
      end
      `PDC_A_REF_LO: next_rdata = ref_pre_div[`PDC_DIV_LO];
      `PDC_A_SYN_HI: next_rdata[`PDC_F_SYN8] = synth_loop_div[`PDC_BIT8];
      `PDC_A_SYN_LO: next_rdata = synth_loop_div[`PDC_DIV_LO];
      `PDC_A_SIN: begin
        next_rdata[`PDC_F_DBL] = freq_doubler_sel;
        next_rdata[`PDC_F_SIN] = synth_input_div;
      end
      `PDC_A_OSC: next_rdata[`PDC_F_OSC] = oscillator_choice;
      default: next_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Divider helpers
  // ----------------------------------------
  // A count that wraps at the ratio; ratio 0 is treated as 1 to avoid a stuck counter.
  function [11:0] pdc_step;
    input [11:0] cnt;
    input [11:0] ratio;
    begin
      if (ratio == 12'h000 || cnt >= ratio - 12'h001)
        pdc_step = 12'h000;
      else
        pdc_step = cnt + 12'h001;
    end
  endfunction

  function pdc_wrap;
    input [11:0] cnt;
    input [11:0] ratio;
    begin
      pdc_wrap = (ratio == 12'h000) || (cnt >= ratio - 12'h001);
    end
  endfunction

  // ----------------------------------------
  // First-stage and synthesizer dividers, lock window
  // ----------------------------------------
  // The dividers count edges of the input levels sampled on ref_clk, so an
  // input must stay below half the ref_clk rate.
  reg ref_d, osc_d, syn_d;
  reg [11:0] ref_cnt, fb_cnt, sec_cnt, syn_cnt, sin_cnt;
  reg [PH_W+1:0] ph_cnt;
  wire ref_rise = ref_in & ~ref_d;
  wire osc_rise = osc_in & ~osc_d;
  wire syn_rise = synth_in & ~syn_d;
  wire fb_wrap = osc_rise & pdc_wrap(fb_cnt, first_feedback_div);
  wire sec_run = ~second_div_powerdown;
  // Chained, the second divider counts wraps of the first, so the ratio is the product
  // and not merely the point where two free-running counters happen to line up.
  wire sec_adv = sec_run & (feedback_chain_sel ? fb_wrap : osc_rise);
  wire sec_edge = sec_adv & pdc_wrap(sec_cnt, {3'h0, second_feedback_div});
  // Feedback output is the first divider alone or the chained pair.
  wire fb_edge = feedback_chain_sel ? sec_edge : fb_wrap;
  wire ref_edge = ref_rise & pdc_wrap(ref_cnt, ref_pre_div);
  // Sample point delayed after the detector edge by the combined phase codes.
  wire [PH_W+1:0] ph_sum = {2'b00, feedback_phase_sel} + {2'b00, ref_phase_sel};
  // Synthesizer input: doubled stage-one output ignores the input divider.
  wire sin_tick = freq_doubler_sel ? (ref_edge | fb_edge) : syn_rise;
  wire sin_edge = freq_doubler_sel ? sin_tick
                  : (synth_input_div == 6'h00 ? syn_rise
                     : (syn_rise & pdc_wrap(sin_cnt, {6'h00, synth_input_div})));

  always @(posedge ref_clk) begin
    if (srst) begin
      ref_d <= 1'b0;
      osc_d <= 1'b0;
      syn_d <= 1'b0;
      ref_cnt <= 12'h000;
      fb_cnt <= 12'h000;
      sec_cnt <= 12'h000;
      syn_cnt <= 12'h000;
      sin_cnt <= 12'h000;
      ph_cnt <= {(PH_W+2){1'b0}};
      ref_div_out <= 1'b0;
      fb_div_out <= 1'b0;
      sec_div_out <= 1'b0;
      lock_sample <= 1'b0;
      synth_loop_out <= 1'b0;
      synth_in_out <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
      ref_d <= ref_in;
      osc_d <= osc_in;
      syn_d <= synth_in;
      if (ref_rise)
        ref_cnt <= pdc_step(ref_cnt, ref_pre_div);
      if (osc_rise)
        fb_cnt <= pdc_step(fb_cnt, first_feedback_div);
      if (!sec_run)
        sec_cnt <= 12'h000;
      else if (sec_adv)
        sec_cnt <= pdc_step(sec_cnt, {3'h0, second_feedback_div});
      if (syn_rise)
        syn_cnt <= pdc_step(syn_cnt, {3'h0, synth_loop_div});
      if (syn_rise && !freq_doubler_sel)
        sin_cnt <= pdc_step(sin_cnt, {6'h00, synth_input_div});
      ref_div_out <= ref_edge;
      fb_div_out <= fb_edge;
      sec_div_out <= sec_edge;
      synth_loop_out <= syn_rise & pdc_wrap(syn_cnt, {3'h0, synth_loop_div});
      synth_in_out <= sin_edge;
      // The window counter restarts on each detector edge.
      if (ref_edge)
        ph_cnt <= {(PH_W+2){1'b0}};
      else if (ph_cnt != {(PH_W+2){1'b1}})
        ph_cnt <= ph_cnt + {{(PH_W+1){1'b0}}, 1'b1};
      lock_sample <= ~ref_edge && (ph_cnt == ph_sum);
    end
  end
endmodule

// >>> bench/pdc_checker.sv
`timescale 1ns/1ns
module pdc_chk (
  input wire ref_clk,
  input wire srst,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire ref_div_out,
  input wire fb_div_out,
  input wire sec_div_out,
  input wire lock_sample
);
  reg pd;
  reg [2:0] fph;
  reg [2:0] rph;
  reg [4:0] since;
  wire [3:0] sum = {1'b0, fph} + {1'b0, rph};
  // Shadow copies of the write traffic, so timing can be judged without the internals.
  always @(posedge ref_clk) begin
    if (srst) begin
      pd <= 1'b0;
      fph <= 3'h0;
      rph <= 3'h0;
      since <= 5'h1f;
    end else begin
      if (reg_wr && reg_addr == 8'h00) pd <= reg_wdata[4];
      if (reg_wr && reg_addr == 8'h00) fph <= reg_wdata[7:5];
      if (reg_wr && reg_addr == 8'h04) rph <= reg_wdata[7:5];
      since <= ref_div_out ? 5'h01 : (since == 5'h1f ? since : since + 5'h01);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  fb_readback_a: assert property (reg_wr && reg_addr == 8'h01 ##1 reg_addr == 8'h01
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("feedback byte readback wrong");
  ref_readback_a: assert property (reg_wr && reg_addr == 8'h05 ##1 reg_addr == 8'h05
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("reference byte readback wrong");
  chain_resv_a: assert property (reg_addr == 8'h03 |=> reg_rdata[6:1] == 6'h00)
    else $error("chain register reserved bits set");
  ref_resv_a: assert property (reg_addr == 8'h04 |=> !reg_rdata[4])
    else $error("reference register reserved bit set");
  synth_hi_a: assert property (reg_addr == 8'h08 |=> reg_rdata[7:1] == 7'h00)
    else $error("synth high register reserved bits set");
  unmapped_read_a: assert property (reg_addr == 8'h06 |=> reg_rdata == 8'h00)
    else $error("unmapped address reads nonzero");
  sec_off_a: assert property (pd && $past(pd) && $past(pd, 2) && $past(pd, 3) |-> !sec_div_out)
    else $error("second divider pulses while powered down");
  ref_pulse_a: assert property (ref_div_out |=> !ref_div_out)
    else $error("reference pulse longer than one cycle");
  fb_pulse_a: assert property (fb_div_out |=> !fb_div_out)
    else $error("feedback pulse longer than one cycle");
  // The window counter starts with the reference pulse, so the sample lands one cycle past the sum.
  lock_pos_a: assert property (lock_sample && sum != 4'h0 |-> since == {1'b0, sum} + 5'h01)
    else $error("lock sample misplaced");
  cover property (lock_sample);
  cover property (reg_wr && reg_addr == 8'h00 ##1 pd);
  cover property (fb_div_out);
endmodule
bind pdc_top pdc_chk chk (.ref_clk, .srst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
  .ref_div_out, .fb_div_out, .sec_div_out, .lock_sample);

// >>> bench/pdc_src.sv
`timescale 1ns/1ns
module pdc_src (
  input wire ref_clk,
  output reg ref_in,
  output reg osc_in,
  output reg synth_in
);
  reg [3:0] c = 4'h0;
  // Periods of six and four cycles keep every edge visible to the sampler.
  always @(negedge ref_clk) begin
    c <= (c == 4'hb) ? 4'h0 : c + 4'h1;
    ref_in <= (c < 4'h3) || (c > 4'h5 && c < 4'h9);
    synth_in <= (c < 4'h3) || (c > 4'h5 && c < 4'h9);
    osc_in <= c[1];
  end
  initial begin
    ref_in = 1'b0;
    osc_in = 1'b0;
    synth_in = 1'b0;
  end
endmodule

// >>> bench/pll_divider_config_test.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module pll_divider_config_test;
  reg ref_clk = 1'b0;
  reg srst = 1'b1;
  reg reg_wr = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire ref_in, osc_in, synth_in;
  wire [5:0] outs;
  integer miscompares = 0;
  integer num_checks = 0;
  integer i;
  // Entry i sits in bits 8*i+7 down to 8*i, so the lists run from the last entry.
  localparam [87:0] ra = {8'h06, 8'h1f, 8'h0c, 8'h09, 8'h08, 8'h05, 8'h04, 8'h03,
    8'h02, 8'h01, 8'h00};
  localparam [87:0] rv = {8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h0c, 8'h00,
    8'h60, 8'h00, 8'h0c};
  localparam [87:0] mk = {8'h00, 8'h01, 8'hbf, 8'hff, 8'h01, 8'hff, 8'hef, 8'h81,
    8'hff, 8'hff, 8'hff};
  always #2 ref_clk = ~ref_clk;
  pdc_src src (.ref_clk(ref_clk), .ref_in(ref_in), .osc_in(osc_in), .synth_in(synth_in));
  pdc_top dut (.ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ref_in(ref_in), .osc_in(osc_in),
    .synth_in(synth_in), .ref_div_out(outs[0]), .fb_div_out(outs[1]), .sec_div_out(outs[2]),
    .lock_sample(outs[3]), .synth_loop_out(outs[4]), .synth_in_out(outs[5]));
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge ref_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(negedge ref_clk);
      reg_addr = a;
      repeat (2) @(negedge ref_clk);
      `CHK("reg_rdata", e, reg_rdata)
    end
  endtask
  // Counts rising edges over a window that every expected period divides exactly.
  task cnt(input integer s, input integer e);
    integer k, n;
    reg p;
    begin
      n = 0;
      repeat (40) @(negedge ref_clk);
      p = outs[s];
      for (k = 0; k < 720; k = k + 1) begin
        @(negedge ref_clk);
        if (outs[s] === 1'b1 && p === 1'b0) n = n + 1;
        p = outs[s];
      end
      `CHK("pulse_count", e, n)
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    srst = 1'b0;
    for (i = 0; i < 11; i++) rd(ra[i*8 +: 8], rv[i*8 +: 8]);
    $display("test reset_values done");
    for (i = 0; i < 11; i++) wr(ra[i*8 +: 8], 8'hff);
    for (i = 0; i < 11; i++) rd(ra[i*8 +: 8], mk[i*8 +: 8]);
    $display("test reserved_bits done");
    wr(8'h00, 8'h40);
    wr(8'h01, 8'h05);
    wr(8'h02, 8'h04);
    wr(8'h03, 8'h00);
    wr(8'h04, 8'h60);
    wr(8'h05, 8'h03);
    wr(8'h08, 8'h00);
    wr(8'h09, 8'h08);
    wr(8'h0c, 8'h03);
    cnt(0, 40);
    cnt(1, 36);
    cnt(2, 45);
    cnt(3, 40);
    cnt(4, 15);
    cnt(5, 40);
    $display("test divide_ratios done");
    wr(8'h03, 8'h01);
    cnt(1, 9);
    wr(8'h00, 8'h50);
    cnt(2, 0);
    wr(8'h0c, 8'h00);
    cnt(5, 120);
    wr(8'h0c, 8'h81);
    cnt(5, 40);
    $display("test modes done");
    close_out;
  end
endmodule
